// [design/acc_defines.svh]
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// Register indices; the byte address of each register is four times its index.
`define ACC_IDX_RES_LO    8'h24
`define ACC_IDX_RES_HI    8'h25
`define ACC_IDX_CTRL      8'h26
`define ACC_IDX_CLKSET    8'h27
`define ACC_IDX_IRQ_STAT  8'h28
`define ACC_IDX_IRQ_MASK  8'h29
`define ACC_ADDR_IDX_LSB  2
// Control register fields.
`define ACC_CH_MSB        2
`define ACC_CFG_LSB       3
`define ACC_CFG_MSB       5
`define ACC_DONE_N_BIT    6
`define ACC_START_BIT     7
// Clock-setting register fields.
`define ACC_CLK_CODE_MSB  1
`define ACC_TEST_BIT      7
// Result packing: the low register holds the two lowest bits at its top.
`define ACC_RES_MSB       9
`define ACC_RES_SPLIT     2
`define ACC_RES_LO_PAD    6'h00
// Interrupt status and mask fields.
`define ACC_IRQ_DONE_BIT  0
`define ACC_IRQ_INIT_BIT  1
// Converter clock codes and the last count of each divider.
`define ACC_CLK_DIV2      2'h0
`define ACC_CLK_DIV8      2'h1
`define ACC_CLK_DIV32     2'h2
`define ACC_DIV2_LAST     5'h01
`define ACC_DIV8_LAST     5'h07
`define ACC_DIV32_LAST    5'h1F
// One conversion lasts 76 converter clocks.
`define ACC_CONV_TADS     7'h4C
// Configuration codes, full pin mask and reset values.
`define ACC_CFG_ALL       3'h7
`define ACC_CFG_OFF       3'h0
`define ACC_MASK_ALL      8'hFF
`define ACC_RES_RST       10'h000
`endif

// [design/acc_pkg.sv]
package acc_pkg;
  // Sequencer states of the conversion engine.
  typedef enum logic {
    ACC_IDLE,
    ACC_CONV
  } acc_seq_t;
  // A full conversion result.
  typedef logic [9:0] acc_result_t;
endpackage : acc_pkg

// [design/acc_conv_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Links the register front end, the clock divider and the sequencer.
interface acc_conv_if;
  logic [1:0]          code;     // Converter clock select.
  logic                powered;  // Converter powered on.
  logic                abort;    // Reset the converter, one-cycle pulse.
  logic                launch;   // Begin a conversion, one-cycle pulse.
  logic                tick;     // One converter clock period elapsed.
  logic                busy;     // Conversion in progress.
  logic                done;     // Conversion finished, one-cycle pulse.
  acc_pkg::acc_result_t result;  // Latest result from the sequencer.
  modport ctl (output code, powered, abort, launch, input busy, done, result);
  modport div (input code, output tick);
  modport seq (input powered, abort, launch, tick, output busy, done, result);
endinterface : acc_conv_if
`default_nettype wire

// [design/acc_clk_div.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"
module acc_clk_div import acc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  acc_conv_if.div  cv
);
  // Last count for each clock code; the undefined code runs as the slowest.
  function automatic logic [4:0] acc_div_last(input logic [1:0] code);
    unique case (code)
      `ACC_CLK_DIV2: acc_div_last = `ACC_DIV2_LAST;
      `ACC_CLK_DIV8: acc_div_last = `ACC_DIV8_LAST;
      default:       acc_div_last = `ACC_DIV32_LAST;
    endcase
  endfunction : acc_div_last

  logic [4:0] cnt;   // Cycles since the last tick.
  logic       tick;  // Registered tick pulse.
  wire        wrap = (cnt >= acc_div_last(cv.code)); // A shorter code wraps at once.

  // ------------------------------------------------------------
  // Divider counter.
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= 5'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? 5'h00 : 5'(cnt + 5'h01);
      tick <= wrap; // R11
    end
  end
  assign cv.tick = tick;

  a_div2_period: assert property (@(posedge clk) disable iff (rst) // R11
    (tick && cv.code == `ACC_CLK_DIV2 ##1 cv.code == `ACC_CLK_DIV2) |-> !tick ##1 tick)
    else $error("divide-by-2 tick period wrong");
  c_div32_tick: cover property (@(posedge clk) disable iff (rst)
    tick && cv.code == `ACC_CLK_DIV32);
endmodule : acc_clk_div
`default_nettype wire

// [design/acc_conv_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"
module acc_conv_seq import acc_pkg::*; #(
  parameter logic [6:0] CONV_TADS = `ACC_CONV_TADS
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire acc_result_t adc_code,
  acc_conv_if.seq         cv
);
  acc_seq_t    state, next_state;  // Engine state.
  logic [6:0]  cnt;                // Converter clocks spent in this conversion.
  logic        done;               // Completion pulse.
  acc_result_t code_s1, code_s2;   // Synchroniser for the analog core output.
  acc_result_t result;             // Captured result.

  // Power-down acts as a standing reset of the engine.
  wire abort = cv.abort | ~cv.powered;
  wire go    = cv.launch & ~abort;
  wire fin   = (state == ACC_CONV) & cv.tick & (cnt == 7'(CONV_TADS - 7'h01));

  // ------------------------------------------------------------
  // Next state.
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ACC_IDLE: if (go) next_state = ACC_CONV;
      ACC_CONV: if (abort || fin) next_state = ACC_IDLE;
    endcase
    if (go) next_state = ACC_CONV; // A new launch restarts the count.
  end

  // ------------------------------------------------------------
  // Registers; only the second synchroniser stage is captured.
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= ACC_IDLE;
      cnt     <= 7'h00;
      done    <= 1'b0;
      code_s1 <= `ACC_RES_RST;
      code_s2 <= `ACC_RES_RST;
      result  <= `ACC_RES_RST;
    end else begin
      state   <= next_state;
      cnt     <= (go | abort | fin) ? 7'h00 : (cv.tick ? 7'(cnt + 7'h01) : cnt);
      done    <= fin & ~abort & ~go;
      code_s1 <= adc_code;
      code_s2 <= code_s1;
      if (fin && !abort && !go) result <= code_s2;
    end
  end
  assign cv.busy   = (state == ACC_CONV);
  assign cv.done   = done;
  assign cv.result = result;

  a_launch_busy: assert property (@(posedge clk) disable iff (rst) // R9
    (cv.launch && !cv.abort && cv.powered) |=> cv.busy)
    else $error("conversion did not begin after start pulse");
  a_done_after_busy: assert property (@(posedge clk) disable iff (rst) // R7
    done |-> $past(cv.busy) && !cv.busy)
    else $error("completion without a running conversion");
endmodule : acc_conv_seq
`default_nettype wire

// [design/acc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"
// Functional notes
// (R1) Two result registers are read-only.
// (R2) High holds bits 9..2, low bits 1..0.
// (R3) Control bits 2..0 pick analog input.
// (R4) Control bits 5..3 set analog pin count.
// (R5) Analog pins lose digital function and pull-up.
// (R6) Configuration zero powers converter down.
// (R7) Read-only flag clears when conversion completes.
// (R8) Start rising resets converter, sets flag.
// (R9) Start high then low launches a conversion.
// (R10) Software keeps start low until done.
// (R11) Clock code picks divide by 2/8/32.
// (R12) Software leaves the test bit alone.
// (R13) Clock-setting bits 6..2 read zero.
// (R14) Software initialises after changing configuration.
// (R15) No initialisation needed when configuration zero.
// (R16) Software reads result after completion.
// (R17) Result held until next completion, updated together.
module acc_top import acc_pkg::*; (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire acc_result_t ADC_CODE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ,
  output logic      [2:0]  ANALOG_CHANNEL,
  output logic      [7:0]  ANALOG_PIN_MASK,
  output logic             ADC_POWER_ON,
  output logic             ADC_CONVERTING
);

  // ------------------------------------------------------------
  // Helper functions.
  // ------------------------------------------------------------

  // Pins that a port configuration code turns analog, lowest pins first.
  // Code 7 takes the whole port; codes 1 to 6 take that many pins.
  function automatic logic [7:0] acc_analog_mask(input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'(8'h01 << cfg) - 8'h01;
    if (cfg == `ACC_CFG_ALL) m = `ACC_MASK_ALL;
    acc_analog_mask = m;
  endfunction : acc_analog_mask

  // Write-one-to-clear update in which a new event always wins.
  function automatic logic [1:0] acc_w1c(input logic [1:0] cur,
                                         input logic [1:0] clr,
                                         input logic [1:0] set);
    acc_w1c = (cur & ~clr) | set;
  endfunction : acc_w1c

  // ------------------------------------------------------------
  // Internal links.
  // ------------------------------------------------------------
  acc_conv_if cv ();

  // The divider paces the conversion; it never stops so that a launch
  // sees its first converter clock within one divider period.
  acc_clk_div u_div (
    .clk (SYS_CLK),
    .rst (SRST),
    .cv  (cv.div)
  );

  // The sequencer owns the timing of one conversion and the captured code.
  acc_conv_seq u_seq (
    .clk      (SYS_CLK),
    .rst      (SRST),
    .adc_code (ADC_CODE),
    .cv       (cv.seq)
  );

  // ------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------
  logic        wait_q;      // Waitrequest, high while no answer is ready.
  logic [31:0] rdata;       // Read data, loaded at the answering edge.
  logic [2:0]  ctl_chan;    // Analog input select.
  logic [2:0]  ctl_cfg;     // Port configuration code.
  logic        done_n;      // Conversion flag, low once a conversion ends.
  logic        start;       // Start bit as last written.
  logic        start_prev;  // Start bit one cycle earlier, for edge detection.
  logic [1:0]  clk_code;    // Converter clock select.
  logic        test_bit;    // Factory test bit, stored but without effect.
  acc_result_t result;      // Result as seen by software.
  logic [1:0]  irq_stat;    // Sticky event bits.
  logic [1:0]  irq_mask;    // Interrupt enables, same layout as status.
  logic        irq;         // Registered interrupt level.
  logic [7:0]  pin_mask;    // Registered analog pin mask.
  logic        power;       // Registered converter power enable.
  logic        converting;  // Registered copy of the sequencer busy state.

  // ------------------------------------------------------------
  // Bus decode.
  // ------------------------------------------------------------

  // A request is answered one cycle after it appears; the slave drops
  // waitrequest for exactly one cycle, and that edge completes it.
  wire       req     = AVS_READ | AVS_WRITE;
  wire       take    = req & ~wait_q;
  wire [7:0] idx     = AVS_ADDRESS[9:`ACC_ADDR_IDX_LSB];
  wire       wr_lane = take & AVS_WRITE & AVS_BYTEENABLE[0];
  wire [7:0] wbyte   = AVS_WRITEDATA[7:0];

  // Per-register write strobes; the result registers have none, so a
  // write to either of them is answered like any other and then dropped.
  wire wr_ctl  = wr_lane & (idx == `ACC_IDX_CTRL); // R1
  wire wr_clk  = wr_lane & (idx == `ACC_IDX_CLKSET);
  wire wr_stat = wr_lane & (idx == `ACC_IDX_IRQ_STAT);
  wire wr_mask = wr_lane & (idx == `ACC_IDX_IRQ_MASK);

  // ------------------------------------------------------------
  // Start-bit edges.
  // ------------------------------------------------------------

  // Edges are taken from the stored bit, so a write that leaves the bit
  // unchanged produces no edge at all.
  wire start_rise = start & ~start_prev;
  wire start_fall = ~start & start_prev;

  // Rising edge resets the converter, falling edge launches it. A second
  // rising edge during a conversion aborts it, which is why software must
  // leave the bit low until the flag has cleared.
  assign cv.abort   = start_rise; // R8
  assign cv.launch  = start_fall; // R9
  assign cv.code    = clk_code;   // R11
  assign cv.powered = (ctl_cfg != `ACC_CFG_OFF); // R6

  // ------------------------------------------------------------
  // Read multiplexer.
  // ------------------------------------------------------------

  // Bits above each register's width, and the unused bits of the low
  // result and clock-setting registers, read as zero.
  wire [7:0] rd_res_lo = {result[`ACC_RES_SPLIT-1:0], `ACC_RES_LO_PAD}; // R2
  wire [7:0] rd_res_hi = result[`ACC_RES_MSB:`ACC_RES_SPLIT];            // R2
  wire [7:0] rd_ctl    = {start, done_n, ctl_cfg, ctl_chan};
  wire [7:0] rd_clk    = {test_bit, 5'h00, clk_code};                    // R13
  wire [7:0] rd_byte   =
    (idx == `ACC_IDX_RES_LO)   ? rd_res_lo :
    (idx == `ACC_IDX_RES_HI)   ? rd_res_hi :
    (idx == `ACC_IDX_CTRL)     ? rd_ctl :
    (idx == `ACC_IDX_CLKSET)   ? rd_clk :
    (idx == `ACC_IDX_IRQ_STAT) ? {6'h00, irq_stat} :
    (idx == `ACC_IDX_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

  // ------------------------------------------------------------
  // Event sources and next values.
  // ------------------------------------------------------------
  wire [1:0] events       = {start_rise, cv.done};
  wire [1:0] stat_clr     = wr_stat ? wbyte[1:0] : 2'h0;
  wire [1:0] next_stat    = acc_w1c(irq_stat, stat_clr, events);
  wire [7:0] next_pinmask = acc_analog_mask(ctl_cfg); // R4

  // ------------------------------------------------------------
  // Bus handshake and read data.
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wait_q <= 1'b1;
      rdata  <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) rdata <= {24'h00_0000, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // Control register; bit 6 is never written by software.
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctl_chan   <= 3'h0;
      ctl_cfg    <= `ACC_CFG_OFF;
      start      <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_prev <= start;
      if (wr_ctl) begin
        ctl_chan <= wbyte[`ACC_CH_MSB:0];              // R3
        ctl_cfg  <= wbyte[`ACC_CFG_MSB:`ACC_CFG_LSB];  // R4
        start    <= wbyte[`ACC_START_BIT];             // R9
      end
    end
  end

  // ------------------------------------------------------------
  // Conversion flag.
  // ------------------------------------------------------------

  // A reset by the start bit outranks a completion in the same cycle,
  // because the sequencer is aborted by that very edge.
  // Power-down leaves the flag as it was; only the two events move it.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      done_n <= 1'b0;
    end else if (start_rise) begin
      done_n <= 1'b1; // R8
    end else if (cv.done) begin
      done_n <= 1'b0; // R7
    end
  end

  // ------------------------------------------------------------
  // Clock-setting register.
  // ------------------------------------------------------------
  // The test bit is stored only so that it reads back; it drives nothing.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      clk_code <= `ACC_CLK_DIV2;
      test_bit <= 1'b0;
    end else if (wr_clk) begin
      clk_code <= wbyte[`ACC_CLK_CODE_MSB:0]; // R11
      test_bit <= wbyte[`ACC_TEST_BIT];
    end
  end

  // ------------------------------------------------------------
  // Result registers.
  // ------------------------------------------------------------

  // Both halves load in one edge, so software never sees a torn pair;
  // the old value stays until the next completion.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      result <= `ACC_RES_RST;
    end else if (cv.done) begin
      result <= cv.result; // R17
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask.
  // ------------------------------------------------------------
  // Status bits are set by the event sources and cleared by writing ones;
  // when both land in one cycle the event wins, so no event is lost.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (wr_mask) irq_mask <= wbyte[1:0];
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // Pin-side outputs.
  // ------------------------------------------------------------

  // The mask lags the configuration by one cycle; pin muxing is far
  // slower than that, and it keeps every pin-side output registered.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pin_mask   <= 8'h00;
      power      <= 1'b0;
      converting <= 1'b0;
    end else begin
      pin_mask   <= next_pinmask;   // R5
      power      <= cv.powered;     // R6
      converting <= cv.busy;
    end
  end

  // ------------------------------------------------------------
  // Output assignments.
  // ------------------------------------------------------------
  assign AVS_READDATA    = rdata;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ             = irq;
  assign ANALOG_CHANNEL  = ctl_chan;
  assign ANALOG_PIN_MASK = pin_mask;
  assign ADC_POWER_ON    = power;
  assign ADC_CONVERTING  = converting;

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  // Every check here runs on the system clock and is off during reset.
  // Checks on pin-side outputs allow for the one-cycle register lag.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  a_result_readonly: assert property ( // R1
    (wr_lane && idx == `ACC_IDX_RES_HI && !cv.done) |=> $stable(result))
    else $error("result changed on a software write");
  a_result_pack: assert property ( // R2
    (take && AVS_READ && idx == `ACC_IDX_RES_LO) |=>
      AVS_READDATA == {24'h00_0000, $past(result[1:0]), 6'h00})
    else $error("low result byte packed wrongly");
  a_channel_follow: assert property ( // R3
    wr_ctl |=> ANALOG_CHANNEL == $past(AVS_WRITEDATA[2:0]))
    else $error("channel select not taken from the write");
  a_pins_all: assert property ( // R4
    (wr_ctl && AVS_WRITEDATA[5:3] == 3'h7) |=> ##1 ANALOG_PIN_MASK == 8'hFF)
    else $error("configuration 7 did not claim all pins");
  a_pins_three: assert property ( // R5
    (wr_ctl && AVS_WRITEDATA[5:3] == 3'h3) |=> ##1 ANALOG_PIN_MASK == 8'h07)
    else $error("configuration 3 did not claim pins 0 to 2");
  a_power_off: assert property ( // R6
    (wr_ctl && AVS_WRITEDATA[5:3] == 3'h0) |=> ##1 !ADC_POWER_ON && ANALOG_PIN_MASK == 8'h00)
    else $error("converter powered with configuration zero");
  a_flag_clear: assert property ( // R7
    (cv.done && !start_rise) |=> !done_n ##1 result == $past(cv.result, 2))
    else $error("flag or result not updated on completion");
  a_flag_set: assert property ( // R8
    (wr_ctl && AVS_WRITEDATA[7] && !start) |=> ##1 done_n)
    else $error("start rising edge did not set the flag");
  a_clk_zero_bits: assert property ( // R13
    (take && AVS_READ && idx == `ACC_IDX_CLKSET) |=> AVS_READDATA[6:2] == 5'h00)
    else $error("unused clock-setting bits read non-zero");
  a_result_hold: assert property ( // R17
    !cv.done |=> $stable(result))
    else $error("result moved without a completion");
  a_bus_answer: assert property (
    (req && wait_q) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("waitrequest not low for exactly one cycle");
  a_irq_level: assert property (
    (irq_stat & irq_mask) != 2'h0 |=> IRQ)
    else $error("unmasked event did not raise the interrupt");

  a_irq_quiet: assert property (
    (irq_stat & irq_mask) == 2'h0 |=> !IRQ)
    else $error("interrupt raised with no unmasked event");
  a_busy_follow: assert property ( // R9
    cv.busy |=> ADC_CONVERTING)
    else $error("running conversion not shown on the pin side");

  // Scenarios that show the main paths were exercised.
  c_start_pulse: cover property (start_rise ##[1:20] start_fall);
  c_conversion:  cover property (start_fall ##[1:1000] cv.done);
  c_irq_raised:  cover property ($rose(IRQ));
endmodule : acc_top
`default_nettype wire

// [verif/acc_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Analog core stand-in: shows the level of the selected input.
// ----------------------------------------------------------------
module acc_adc_model import acc_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [2:0]      chan,
  input  wire logic            power,
  input  wire logic [7:0][9:0] lvl,
  output var  acc_result_t     code
);
  // Unpowered, the word toggles so stale data is never mistaken for a level.
  always_ff @(posedge clk) begin
    if (rst) begin
      code <= 10'h000;
    end else begin
      code <= power ? lvl[chan] : ~code;
    end
  end
endmodule : acc_adc_model
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import acc_pkg::*;;
  logic            SYS_CLK = 1'b0;
  logic            SRST = 1'b1;
  logic [9:0]      AVS_ADDRESS = 10'h000;
  logic            AVS_READ = 1'b0;
  logic            AVS_WRITE = 1'b0;
  logic [31:0]     AVS_WRITEDATA = 32'h0;
  acc_result_t     ADC_CODE;
  logic [31:0]     AVS_READDATA;
  logic            AVS_WAITREQUEST;
  logic            IRQ;
  logic [2:0]      ANALOG_CHANNEL;
  logic [7:0]      ANALOG_PIN_MASK;
  logic            ADC_POWER_ON;
  logic            ADC_CONVERTING;
  logic [7:0][9:0] lvl;       // Input levels held by the analog model.
  acc_result_t     ref_q[$];  // Results expected, in launch order.
  logic [31:0]     rd;        // Last read data.
  logic [2:0]      ch;        // Channel in use.
  int              bad_count = 0;
  int              n_tests = 0;
  int              k;
  acc_top i_dut (.SYS_CLK(SYS_CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .ADC_CODE(ADC_CODE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .ANALOG_CHANNEL(ANALOG_CHANNEL),
    .ANALOG_PIN_MASK(ANALOG_PIN_MASK), .ADC_POWER_ON(ADC_POWER_ON),
    .ADC_CONVERTING(ADC_CONVERTING));
  acc_adc_model i_adc (.clk(SYS_CLK), .rst(SRST), .chan(ANALOG_CHANNEL),
    .power(ADC_POWER_ON), .lvl(lvl), .code(ADC_CODE));
  // The clock runs at 10 MHz.
  initial forever #50 SYS_CLK = ~SYS_CLK;
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // One request, held until waitrequest is seen low; an extra edge keeps drives apart.
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= {24'h0, wd};
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge SYS_CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n == 20) begin
      bad_count++;
      final_report();
    end
    @(posedge SYS_CLK);
  endtask : bus
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk("register", {24'h0, exp}, rd);
  endtask : rdchk
  // Full start pulse, poll for completion, then compare time and result.
  task automatic conv(input int div);
    int n;
    time t0;
    acc_result_t r;
    bus(1'b1, 8'h26, {5'h07, ch});
    bus(1'b1, 8'h26, {5'h17, ch});
    repeat (2) @(posedge SYS_CLK);
    rdchk(8'h26, {5'h1F, ch});
    ref_q.push_back(lvl[ch]);
    bus(1'b1, 8'h26, {5'h07, ch});
    t0 = $time;
    repeat (2) @(posedge SYS_CLK);
    chk("converting", 32'h1, {31'h0, ADC_CONVERTING});
    for (n = 0; n < 1000; n++) begin
      bus(1'b0, 8'h26, 8'h00);
      if (rd[6] === 1'b0) break;
    end
    if (n == 1000) begin
      bad_count++;
      final_report();
    end
    chk("converting", 32'h0, {31'h0, ADC_CONVERTING});
    n = int'(($time - t0) / 100);
    chk("conv time", 32'h1, {31'h0, n >= 75 * div + 5 && n <= 76 * div + 6});
    r = ref_q.pop_front();
    bus(1'b1, 8'h25, 8'hFF);
    bus(1'b1, 8'h24, 8'hFF);
    rdchk(8'h25, r[9:2]);
    rdchk(8'h24, {r[1:0], 6'h00});
  endtask : conv
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3D40));
    for (k = 0; k < 8; k++) lvl[k] = 10'($urandom_range(1023));
    repeat (12) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    // Reset values, with one unmapped index at the end.
    for (k = 8'h24; k < 8'h2B; k++) rdchk(8'(k), 8'h00);
    bus(1'b1, 8'h2A, 8'hFF);
    rdchk(8'h2A, 8'h00);
    bus(1'b1, 8'h27, 8'h7F);
    rdchk(8'h27, 8'h03);
    // Every pin configuration code, each with a random channel.
    for (k = 0; k < 8; k++) begin
      ch = 3'($urandom_range(7));
      bus(1'b1, 8'h26, {2'b00, 3'(k), ch});
      @(posedge SYS_CLK);
      chk("pin mask", (k == 7) ? 32'hFF : (32'h1 << k) - 1, {24'h0, ANALOG_PIN_MASK});
      chk("power", {31'h0, k != 0}, {31'h0, ADC_POWER_ON});
      chk("channel", {29'h0, ch}, {29'h0, ANALOG_CHANNEL});
    end
    // One conversion at each defined clock divider.
    for (k = 0; k < 3; k++) begin
      bus(1'b1, 8'h27, 8'(k));
      ch = 3'($urandom_range(7));
      conv((k == 0) ? 2 : (k == 1) ? 8 : 32);
    end
    // Interrupt: both events pending and masked, then the done event unmasked and cleared.
    rdchk(8'h28, 8'h03);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    bus(1'b1, 8'h29, 8'h01);
    repeat (2) @(posedge SYS_CLK);
    chk("irq raised", 32'h1, {31'h0, IRQ});
    bus(1'b1, 8'h28, 8'h01);
    repeat (2) @(posedge SYS_CLK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    rdchk(8'h28, 8'h02);
    final_report();
  end
endmodule : tb
`default_nettype wire
